//--- design/rst_seq_pkg.sv
// shared constants and types for the reset sequencer
package rst_seq_pkg;

    // stabilization wait: 2^17 main-clock periods
    localparam int unsigned SETTLE_EXP    = 17;
    localparam int unsigned SETTLE_CYCLES = 1 << SETTLE_EXP;

    // least low time of the reset pin, in ns, and its cycle count at 200 MHz
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned PIN_LOW_MIN_NS  = 10000;
    localparam int unsigned PIN_LOW_CYCLES  = (PIN_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // reset vector location
    localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0001;

    // after-reset register values
    localparam logic [7:0] PSW_RST       = 8'h02;
    localparam logic [7:0] LATCH_RST     = 8'h00;
    localparam logic [7:0] DIR_RST       = 8'hFF;
    localparam logic [7:0] PULLUP_RST    = 8'h00;
    localparam logic [7:0] CLKCTL_RST    = 8'h04;
    localparam logic [7:0] OSC_SEL_RST   = 8'h04;
    localparam logic [7:0] MEMSIZE_RST   = 8'hCF;
    localparam logic [7:0] PERIPH_RST    = 8'h00;
    localparam logic [7:0] DISP0_RST     = 8'h10;
    localparam logic [7:0] DISP1_RST     = 8'h01;
    localparam logic [7:0] DISP2_RST     = 8'h00;
    localparam logic [7:0] EDGE_RST      = 8'h00;
    localparam logic [7:0] IRQ_REQ_RST   = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST  = 8'hFF;
    localparam logic [7:0] IRQ_PRIO_RST  = 8'hFF;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SETTLE,
        ST_FETCH_LO,
        ST_RUN
    } seq_state_t;

    // core-facing register image loaded while reset holds
    typedef struct packed {
        logic [7:0] processor_status_word;
        logic [7:0] port_latch;
        logic [7:0] port_direction_0;
        logic [7:0] pullup_option_0;
        logic [7:0] cpu_clock_control;
        logic [7:0] osc_settle_select;
        logic [7:0] memory_size_select;
        logic [7:0] remote_timer_capture_0;
        logic [7:0] remote_timer_mode;
        logic [7:0] timer8_compare_0;
        logic [7:0] timer8_mode_0;
        logic [7:0] watchdog_clock_select;
        logic [7:0] watchdog_mode_reg;
        logic [7:0] converter_mode_reg;
        logic [7:0] analog_channel_select;
        logic [7:0] serial_b_mode;
        logic [7:0] serial_a_shift;
        logic [7:0] serial_a_mode;
        logic [7:0] auto_xfer_control;
        logic [7:0] auto_xfer_interval;
        logic [7:0] display_mode_0;
        logic [7:0] display_mode_1;
        logic [7:0] display_mode_2;
        logic [7:0] rising_edge_enable;
        logic [7:0] falling_edge_enable;
        logic [7:0] irq_request_flags;
        logic [7:0] irq_mask_flags;
        logic [7:0] irq_priority_flags;
    } init_image_t;

    // reset values of the image
    localparam init_image_t INIT_IMAGE = '{
        processor_status_word:  PSW_RST,
        port_latch:             LATCH_RST,
        port_direction_0:       DIR_RST,
        pullup_option_0:        PULLUP_RST,
        cpu_clock_control:      CLKCTL_RST,
        osc_settle_select:      OSC_SEL_RST,
        memory_size_select:     MEMSIZE_RST,
        remote_timer_capture_0: PERIPH_RST,
        remote_timer_mode:      PERIPH_RST,
        timer8_compare_0:       PERIPH_RST,
        timer8_mode_0:          PERIPH_RST,
        watchdog_clock_select:  PERIPH_RST,
        watchdog_mode_reg:      PERIPH_RST,
        converter_mode_reg:     PERIPH_RST,
        analog_channel_select:  PERIPH_RST,
        serial_b_mode:          PERIPH_RST,
        serial_a_shift:         PERIPH_RST,
        serial_a_mode:          PERIPH_RST,
        auto_xfer_control:      PERIPH_RST,
        auto_xfer_interval:     PERIPH_RST,
        display_mode_0:         DISP0_RST,
        display_mode_1:         DISP1_RST,
        display_mode_2:         DISP2_RST,
        rising_edge_enable:     EDGE_RST,
        falling_edge_enable:    EDGE_RST,
        irq_request_flags:      IRQ_REQ_RST,
        irq_mask_flags:         IRQ_MASK_RST,
        irq_priority_flags:     IRQ_PRIO_RST
    };

endpackage

//--- design/pin_sync.sv
// two-stage synchroniser for the reset pin
`timescale 1ns/10ps
module pin_sync
    import rst_seq_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // idle level of the pin is high
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

//--- design/settle_counter.sv
// oscillation-stabilization interval counter
`timescale 1ns/10ps
module settle_counter
    import rst_seq_pkg::*;
#(
    parameter int unsigned COUNT = SETTLE_CYCLES
)
(
    input  wire logic clk_in,
    input  wire logic srst_in,
    input  wire logic clear_in,
    input  wire logic run_in,
    output logic      done_out
);

    localparam int unsigned W = $clog2(COUNT + 1);

    initial begin
        if (COUNT < 2) $error("settle_counter: COUNT must be at least 2");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_q;
    logic         done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        if (clear_in) begin
            cnt_d  = '0;
            done_d = 1'b0;
        end else if (run_in && !done_q) begin
            cnt_d  = cnt_q + 1'b1;
            done_d = (cnt_q == W'(COUNT - 1));
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_out = done_q;

endmodule

//--- design/reset_sequencer.sv
// reset sequencer: reset sources, stabilization wait, vector fetch, init image
`timescale 1ns/10ps
module reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int unsigned SETTLE_COUNT = SETTLE_CYCLES,
    parameter int unsigned PIN_COUNT    = 8
)
(
    // clock and reset
    input  wire logic                 CLK_IN,
    input  wire logic                 SRST_IN,
    // reset sources
    input  wire logic                 RESET_N_IN,
    input  wire logic                 WDT_OVF_IN,
    // stop mode state from the standby controller
    input  wire logic                 STOP_MODE_IN,
    // vector fetch from program memory
    output logic                      VEC_RD_OUT,
    output logic [15:0]               VEC_ADDR_OUT,
    input  wire logic [7:0]           VEC_DATA_IN,
    // core control
    output logic                      CORE_RESET_OUT,
    output logic                      PC_LOAD_OUT,
    output logic [15:0]               PROGRAM_COUNTER_OUT,
    output init_image_t               INIT_IMAGE_OUT,
    output logic                      STOP_HOLD_OUT,
    // pin drive gate, high means pins released to high impedance
    output logic [PIN_COUNT-1:0]      PIN_OE_N_OUT
);

    initial begin
        if (SETTLE_COUNT < 2) $error("reset_sequencer: SETTLE_COUNT must be at least 2");
        if (PIN_COUNT < 1) $error("reset_sequencer: PIN_COUNT must be at least 1");
    end

    //////////////////////////////////////////////////////////////////////
    // reset sources
    logic pin_level;

    pin_sync u_pin_sync (
        .clk_in   (CLK_IN),
        .srst_in  (SRST_IN),
        .async_in (RESET_N_IN),
        .sync_out (pin_level)
    );

    logic any_reset;
    // both sources feed the same sequence
    assign any_reset = !pin_level || WDT_OVF_IN;

    //////////////////////////////////////////////////////////////////////
    // sequence state
    seq_state_t state_q;
    seq_state_t state_d;
    logic [7:0] vec_lo_q;
    logic [7:0] vec_lo_d;
    logic       settle_done;
    logic       settle_clear;

    settle_counter #(
        .COUNT (SETTLE_COUNT)
    ) u_settle (
        .clk_in   (CLK_IN),
        .srst_in  (SRST_IN),
        .clear_in (settle_clear),
        .run_in   (state_q == ST_SETTLE),
        .done_out (settle_done)
    );

    always_comb begin
        state_d      = state_q;
        vec_lo_d     = vec_lo_q;
        settle_clear = 1'b0;
        if (any_reset) begin
            state_d      = ST_RESET;
            settle_clear = 1'b1;
        end else begin
            unique case (state_q)
                ST_RESET: begin
                    // watchdog reset needs no release by software
                    state_d = ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (settle_done) begin
                        state_d = ST_FETCH_LO;
                    end
                end
                ST_FETCH_LO: begin
                    vec_lo_d = VEC_DATA_IN;
                    state_d  = ST_RUN;
                end
                ST_RUN: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            state_q  <= ST_RESET;
            vec_lo_q <= 8'h00;
        end else begin
            state_q  <= state_d;
            vec_lo_q <= vec_lo_d;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // output registers
    logic                 core_rst_q;
    logic                 core_rst_d;
    logic                 pc_load_q;
    logic                 pc_load_d;
    logic [15:0]          pc_q;
    logic [15:0]          pc_d;
    logic                 vec_rd_q;
    logic                 vec_rd_d;
    logic [15:0]          vec_addr_q;
    logic [15:0]          vec_addr_d;
    init_image_t          image_q;
    init_image_t          image_d;
    logic                 stop_hold_q;
    logic                 stop_hold_d;
    logic [PIN_COUNT-1:0] oe_n_q;
    logic [PIN_COUNT-1:0] oe_n_d;
    logic                 in_reset_d;

    always_comb begin
        // core stays held until the cycle in which the program counter is loaded
        in_reset_d  = (state_d != ST_RUN) || (state_q == ST_FETCH_LO);
        core_rst_d  = in_reset_d;
        // pins float from reset entry until execution begins
        oe_n_d      = in_reset_d ? '1 : '0;
        // stop state kept only while a pin or watchdog reset is held
        stop_hold_d = (state_d == ST_RESET) && STOP_MODE_IN;
        // image held at reset values throughout reset; data memory untouched
        image_d     = in_reset_d ? INIT_IMAGE : image_q;
        vec_rd_d    = 1'b0;
        vec_addr_d  = vec_addr_q;
        pc_load_d   = 1'b0;
        pc_d        = pc_q;
        if (state_q == ST_SETTLE && state_d == ST_FETCH_LO) begin
            vec_rd_d   = 1'b1;
            vec_addr_d = VEC_LO_ADDR;
        end else if (state_q == ST_FETCH_LO && state_d == ST_RUN) begin
            vec_rd_d   = 1'b1;
            vec_addr_d = VEC_HI_ADDR;
        end
        if (state_q == ST_RUN && vec_rd_q && !any_reset) begin
            // high byte arrives in the same cycle as its read strobe, one cycle after the low byte
            pc_d      = {VEC_DATA_IN, vec_lo_q};
            pc_load_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            core_rst_q  <= 1'b1;
            pc_load_q   <= 1'b0;
            pc_q        <= 16'h0000;
            vec_rd_q    <= 1'b0;
            vec_addr_q  <= 16'h0000;
            image_q     <= INIT_IMAGE;
            stop_hold_q <= 1'b0;
            oe_n_q      <= '1;
        end else begin
            core_rst_q  <= core_rst_d;
            pc_load_q   <= pc_load_d;
            pc_q        <= pc_d;
            vec_rd_q    <= vec_rd_d;
            vec_addr_q  <= vec_addr_d;
            image_q     <= image_d;
            stop_hold_q <= stop_hold_d;
            oe_n_q      <= oe_n_d;
        end
    end

    assign CORE_RESET_OUT      = core_rst_q;
    assign PC_LOAD_OUT         = pc_load_q;
    assign PROGRAM_COUNTER_OUT = pc_q;
    assign VEC_RD_OUT          = vec_rd_q;
    assign VEC_ADDR_OUT        = vec_addr_q;
    assign INIT_IMAGE_OUT      = image_q;
    assign STOP_HOLD_OUT       = stop_hold_q;
    assign PIN_OE_N_OUT        = oe_n_q;

    //////////////////////////////////////////////////////////////////////
    // checks
    chk_wdt_resets: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        WDT_OVF_IN |=> (CORE_RESET_OUT && state_q == ST_RESET))
        else $error("watchdog overflow did not reset");

    chk_pins_float: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        CORE_RESET_OUT |-> (PIN_OE_N_OUT == '1))
        else $error("pins driven during reset");

    chk_settle_len: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (state_q == ST_SETTLE && u_settle.cnt_q == '0 && !any_reset) |-> !settle_done)
        else $error("stabilization ended early");

    chk_vec_order: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (VEC_RD_OUT && VEC_ADDR_OUT == VEC_LO_ADDR && !any_reset)
        |=> (VEC_RD_OUT && VEC_ADDR_OUT == VEC_HI_ADDR))
        else $error("vector bytes out of order");

    chk_pc_load: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (VEC_RD_OUT && VEC_ADDR_OUT == VEC_HI_ADDR && state_q == ST_RUN && !any_reset)
        |=> (PC_LOAD_OUT && PROGRAM_COUNTER_OUT == {$past(VEC_DATA_IN), vec_lo_q}))
        else $error("program counter not loaded from vector");

    chk_image_psw: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        CORE_RESET_OUT |-> (INIT_IMAGE_OUT.processor_status_word == PSW_RST))
        else $error("status word wrong in reset");

    chk_image_ports: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        CORE_RESET_OUT |-> (INIT_IMAGE_OUT.port_direction_0 == DIR_RST && INIT_IMAGE_OUT.irq_mask_flags == IRQ_MASK_RST))
        else $error("port or mask image wrong in reset");

    chk_image_misc: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        CORE_RESET_OUT |-> (INIT_IMAGE_OUT.memory_size_select == MEMSIZE_RST
            && INIT_IMAGE_OUT.osc_settle_select == OSC_SEL_RST && INIT_IMAGE_OUT.display_mode_0 == DISP0_RST))
        else $error("control image wrong in reset");

    chk_stop_hold: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        STOP_HOLD_OUT |-> (CORE_RESET_OUT && PIN_OE_N_OUT == '1))
        else $error("stop hold outside reset");

    chk_pin_reset: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !pin_level |=> (CORE_RESET_OUT && state_q == ST_RESET))
        else $error("pin low did not reset");

    chk_stop_kept: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (STOP_MODE_IN && !pin_level) |=> STOP_HOLD_OUT)
        else $error("stop state not kept during pin reset");

    chk_release_load: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        $fell(CORE_RESET_OUT) |-> PC_LOAD_OUT)
        else $error("core released without program counter load");

    chk_pc_stable: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        !PC_LOAD_OUT |-> $stable(PROGRAM_COUNTER_OUT))
        else $error("program counter changed without load");

    chk_vec_single: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (VEC_RD_OUT && VEC_ADDR_OUT == VEC_HI_ADDR) |=> !VEC_RD_OUT)
        else $error("extra vector read");

    chk_wait_held: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (state_q == ST_SETTLE || state_q == ST_FETCH_LO) |-> (CORE_RESET_OUT && PIN_OE_N_OUT == '1))
        else $error("core or pins released during wait");

    chk_image_timers: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        CORE_RESET_OUT |-> ((INIT_IMAGE_OUT.remote_timer_capture_0 | INIT_IMAGE_OUT.remote_timer_mode
            | INIT_IMAGE_OUT.timer8_compare_0 | INIT_IMAGE_OUT.timer8_mode_0 | INIT_IMAGE_OUT.watchdog_clock_select
            | INIT_IMAGE_OUT.watchdog_mode_reg | INIT_IMAGE_OUT.converter_mode_reg
            | INIT_IMAGE_OUT.analog_channel_select | INIT_IMAGE_OUT.serial_b_mode | INIT_IMAGE_OUT.serial_a_shift
            | INIT_IMAGE_OUT.serial_a_mode | INIT_IMAGE_OUT.auto_xfer_control
            | INIT_IMAGE_OUT.auto_xfer_interval) == PERIPH_RST))
        else $error("peripheral image not cleared in reset");

    chk_image_irq: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        CORE_RESET_OUT |-> ((INIT_IMAGE_OUT.rising_edge_enable | INIT_IMAGE_OUT.falling_edge_enable) == EDGE_RST
            && INIT_IMAGE_OUT.irq_request_flags == IRQ_REQ_RST && INIT_IMAGE_OUT.irq_priority_flags == IRQ_PRIO_RST
            && INIT_IMAGE_OUT.port_latch == LATCH_RST && INIT_IMAGE_OUT.pullup_option_0 == PULLUP_RST))
        else $error("edge, flag or port image wrong in reset");

    //////////////////////////////////////////////////////////////////////
    // settle length monitor, counts cycles spent in the wait
    logic [31:0] settle_seen_q;
    logic [31:0] settle_seen_d;

    always_comb begin
        settle_seen_d = settle_seen_q;
        if (state_q != ST_SETTLE) begin
            settle_seen_d = 32'h0000_0000;
        end else if (settle_seen_q != 32'hFFFF_FFFF) begin
            settle_seen_d = settle_seen_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            settle_seen_q <= 32'h0000_0000;
        end else begin
            settle_seen_q <= settle_seen_d;
        end
    end

    chk_settle_min: assert property (@(posedge CLK_IN) disable iff (SRST_IN)
        (state_q == ST_FETCH_LO) |-> (settle_seen_q >= SETTLE_COUNT))
        else $error("stabilization shorter than its count");

endmodule

//--- tb/reset_source_model.sv
// partner model: external reset generator on the pin and reset vector memory
`timescale 1ns/10ps
module reset_source_model
    import rst_seq_pkg::*;
(
    // clock
    input  wire logic        clk_in,
    // reset pin generator
    input  wire logic        start_in,
    output logic             reset_n_out,
    output logic             busy_out,
    // vector memory
    input  wire logic        rd_in,
    input  wire logic [15:0] addr_in,
    input  wire logic [7:0]  vec_lo_in,
    input  wire logic [7:0]  vec_hi_in,
    output logic [7:0]       data_out
);
    int unsigned low_cnt = 0;

    ////////////////////////////////////////////////////////////////////////////
    // pin held low for the full minimum low time once started, pulled up otherwise
    always @(posedge clk_in) begin
        if (start_in && low_cnt == 0) begin
            low_cnt <= PIN_LOW_CYCLES;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end
    end
    assign reset_n_out = (low_cnt == 0);
    assign busy_out    = (low_cnt != 0);

    ////////////////////////////////////////////////////////////////////////////
    // byte shown while its strobe stands, taken at the edge ending it; junk otherwise
    always_comb begin
        if (rd_in && addr_in == 16'h0000) begin
            data_out = vec_lo_in;
        end else if (rd_in && addr_in == 16'h0001) begin
            data_out = vec_hi_in;
        end else begin
            data_out = ~vec_lo_in;
        end
    end
endmodule

//--- tb/reset_sequencer_tb_top.sv
// self-checking testbench for the reset sequencer
`timescale 1ns/10ps
module reset_sequencer_tb_top;
    import rst_seq_pkg::*;
    localparam int unsigned SETTLE_N = 16;
    localparam int unsigned MAX_WAIT = 400;

    logic        clk       = 1'b0;
    logic        srst      = 1'b1;
    logic        wdt_ovf   = 1'b0;
    logic        stop_mode = 1'b0;
    logic        gen_start = 1'b0;
    logic [7:0]  vec_lo    = 8'h34;
    logic [7:0]  vec_hi    = 8'h12;
    logic        reset_n, gen_busy, vec_rd, core_reset, pc_load, stop_hold;
    logic [7:0]  vec_data, pin_oe_n;
    logic [15:0] vec_addr, pc;
    init_image_t image;
    logic [15:0] rd_addrs[$];
    int unsigned err_count = 0;
    int unsigned n_tests   = 0;
    int unsigned cyc;

    always #2.5 clk = ~clk;

    reset_sequencer #(.SETTLE_COUNT(SETTLE_N), .PIN_COUNT(8)) dut (
        .CLK_IN(clk), .SRST_IN(srst), .RESET_N_IN(reset_n), .WDT_OVF_IN(wdt_ovf),
        .STOP_MODE_IN(stop_mode), .VEC_RD_OUT(vec_rd), .VEC_ADDR_OUT(vec_addr),
        .VEC_DATA_IN(vec_data), .CORE_RESET_OUT(core_reset), .PC_LOAD_OUT(pc_load),
        .PROGRAM_COUNTER_OUT(pc), .INIT_IMAGE_OUT(image), .STOP_HOLD_OUT(stop_hold),
        .PIN_OE_N_OUT(pin_oe_n));

    reset_source_model model (
        .clk_in(clk), .start_in(gen_start), .reset_n_out(reset_n), .busy_out(gen_busy),
        .rd_in(vec_rd), .addr_in(vec_addr), .vec_lo_in(vec_lo), .vec_hi_in(vec_hi),
        .data_out(vec_data));

    always @(negedge clk) begin
        if (vec_rd === 1'b1) begin
            rd_addrs.push_back(vec_addr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cycles(input int unsigned n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check_image();
        check(image.processor_status_word, 8'h02, "status word");
        check({image.port_latch, image.port_direction_0, image.pullup_option_0}, 24'h00_FF00, "ports");
        check({image.cpu_clock_control, image.osc_settle_select}, 16'h0404, "clock control");
        check(image.memory_size_select, 8'hCF, "memory size");
        check(image.remote_timer_capture_0 | image.remote_timer_mode | image.timer8_compare_0
              | image.timer8_mode_0 | image.watchdog_clock_select | image.watchdog_mode_reg, 8'h00, "timers");
        check(image.converter_mode_reg | image.analog_channel_select, 8'h00, "converter");
        check(image.serial_b_mode | image.serial_a_shift | image.serial_a_mode
              | image.auto_xfer_control | image.auto_xfer_interval, 8'h00, "serial");
        check({image.display_mode_0, image.display_mode_1, image.display_mode_2}, 24'h10_0100, "display");
        check(image.rising_edge_enable | image.falling_edge_enable | image.irq_request_flags, 8'h00, "irq low");
        check({image.irq_mask_flags, image.irq_priority_flags}, 16'hFFFF, "irq masks");
    endtask

    // waits for the vector load, all pins floating and core held meanwhile
    task automatic wait_load(output int unsigned n);
        int unsigned bad;
        bad = 0;
        n   = 0;
        while (pc_load !== 1'b1) begin
            @(negedge clk);
            n++;
            if (pc_load !== 1'b1 && (core_reset !== 1'b1 || pin_oe_n !== 8'hFF)) begin
                bad++;
            end
            if (n > MAX_WAIT) begin
                err_count++;
                $display("wrong value at %0t: no vector load seen", $time);
                summarize();
            end
        end
        check(bad, 0, "released during wait");
    endtask

    task automatic check_load(input int unsigned n);
        check(pc, {vec_hi, vec_lo}, "program counter");
        check({core_reset, pin_oe_n}, 9'h000, "release at load");
        check(rd_addrs.size(), 2, "vector reads");
        if (rd_addrs.size() == 2) begin
            check({rd_addrs[0], rd_addrs[1]}, 32'h0000_0001, "vector order");
        end
        check(n >= SETTLE_N && n <= SETTLE_N + 10, 1, "settle length");
        check(image.memory_size_select, 8'hCF, "memory size left for software");
    endtask

    task automatic wdt_pulse();
        wdt_ovf = 1'b1;
        @(negedge clk);
        wdt_ovf = 1'b0;
    endtask

    // waits for the generator to let the pin go high again
    task automatic wait_release();
        int unsigned k;
        k = 0;
        while (gen_busy !== 1'b0) begin
            @(negedge clk);
            k++;
            if (k > PIN_LOW_CYCLES + 10) begin
                err_count++;
                $display("wrong value at %0t: reset pin never released", $time);
                summarize();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_pin_reset();
        vec_lo    = 8'h5A;
        vec_hi    = 8'hC3;
        gen_start = 1'b1;
        @(negedge clk);
        gen_start = 1'b0;
        cycles(10);
        check({core_reset, pin_oe_n}, 9'h1FF, "pin reset held");
        check_image();
        wait_release();
        rd_addrs.delete();
        wait_load(cyc);
        check_load(cyc);
        $display("test pin reset done");
    endtask

    task automatic t_wdt_reset();
        vec_lo = 8'h78;
        vec_hi = 8'h56;
        cycles(3);
        wdt_pulse();
        cycles(2);
        check({core_reset, pin_oe_n}, 9'h1FF, "watchdog reset held");
        check_image();
        rd_addrs.delete();
        wait_load(cyc);
        check_load(cyc + 2);
        $display("test watchdog reset done");
    endtask

    task automatic t_restart();
        vec_lo = 8'h9A;
        vec_hi = 8'hBC;
        cycles(3);
        wdt_pulse();
        cycles(8);
        rd_addrs.delete();
        wdt_pulse();
        wait_load(cyc);
        check_load(cyc);
        $display("test restart in settle done");
    endtask

    task automatic t_stop();
        vec_lo    = 8'hE1;
        vec_hi    = 8'h0F;
        stop_mode = 1'b1;
        gen_start = 1'b1;
        @(negedge clk);
        gen_start = 1'b0;
        cycles(20);
        check({stop_hold, pin_oe_n}, 9'h1FF, "stop kept, pins float");
        wait_release();
        stop_mode = 1'b0;
        rd_addrs.delete();
        wait_load(cyc);
        check_load(cyc);
        check(stop_hold, 1'b0, "stop hold after load");
        $display("test stop mode reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cycles(10);
        check({core_reset, pin_oe_n}, 9'h1FF, "power-on reset");
        check_image();
        srst = 1'b0;
        rd_addrs.delete();
        wait_load(cyc);
        check_load(cyc);
        $display("test power-on done");
        t_pin_reset();
        t_wdt_reset();
        t_restart();
        t_stop();
        summarize();
    end
endmodule
